// *** rtl/ssd_regs.sv ***
// Identification, error, power mode status and output data registers of the sensor.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Read-only identification register at address zero returns a fixed code.
// - Reading the error register clears error bit 6 and the error code field; bit 0 stays set.
// - A discarded command sets error bit 6.
// - Error code field holds only the documented encodings; others are reserved.
// - The first error code is kept until the field is cleared.
// - Boot failure sets error bit 0, which only a power-on reset clears.
// - Power mode fields use the documented two-bit encodings per sensor.
// - A power mode field changes only once the new mode is effective.
// - A newly enabled sensor is reported once the sensing element runs.
// - Mode changes come from host commands; gyroscope also from events.
// - The 20-byte data block stays constant through one host transaction.
// - Data block from 0x04 holds little-endian words: mag, hall, gyro, accel.
// - Reading a sensor's data bytes clears that sensor's data ready flag.
// - Any single byte read of a sensor's data clears its ready flag.
module ssd_regs
    import ssd_pkg::*;
#(
    parameter logic [7:0] IDENT_VALUE = SSD_IDENT_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire ssd_host_req_t host_req,
    input wire logic txn_active,
    input wire ssd_data_t live_data,
    input wire ssd_drdy_t new_data,
    input wire logic cmd_dropped,
    input wire logic err_event,
    input wire logic [3:0] err_code_in,
    input wire logic boot_fail,
    input wire logic pm_effective,
    input wire ssd_pmu_t pm_in,
    output logic [7:0] rdata,
    output logic rvalid,
    output ssd_drdy_t drdy
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic code_legal(input logic [3:0] c);
        code_legal = (c == SSD_ERR_GENERAL_A) || (c == SSD_ERR_GENERAL_B) ||
                     (c == SSD_ERR_LP_INT_PREFILT) || (c == SSD_ERR_ODR_MISMATCH) ||
                     (c == SSD_ERR_LP_PREFILT);
    endfunction

    function automatic logic mode_legal(input logic [1:0] m, input logic is_gyr);
        if (is_gyr) begin
            mode_legal = (m != SSD_PM_LOW_POWER);
        end else begin
            mode_legal = (m != SSD_PM_FAST_START);
        end
    endfunction

    // ------------------------------------------------------------
    // Data shadow
    // ------------------------------------------------------------
    ssd_data_t shadow;
    logic [159:0] shadow_vec;
    logic [7:0] data_index;

    ssd_shadow u_shadow (
        .clk(clk),
        .reset(reset),
        .hold(txn_active),
        .live(live_data),
        .shadow(shadow)
    );

    assign shadow_vec = shadow;
    assign data_index = host_req.addr - SSD_ADDR_DATA_FIRST;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    logic rd_error;
    logic rd_mag;
    logic rd_gyr;
    logic rd_acc;
    logic [7:0] rd_byte;

    assign rd_error = host_req.rd && (host_req.addr == SSD_ADDR_ERROR);
    assign rd_mag = host_req.rd &&
                    in_range(host_req.addr, SSD_ADDR_DATA_FIRST, SSD_ADDR_GYR_FIRST - 8'h01);
    assign rd_gyr = host_req.rd &&
                    in_range(host_req.addr, SSD_ADDR_GYR_FIRST, SSD_ADDR_ACC_FIRST - 8'h01);
    assign rd_acc = host_req.rd &&
                    in_range(host_req.addr, SSD_ADDR_ACC_FIRST, SSD_ADDR_DATA_LAST);

    // ------------------------------------------------------------
    // Error register
    // ------------------------------------------------------------
    logic fatal_ff;
    logic drop_ff;
    logic [3:0] code_ff;
    logic nxt_fatal;
    logic nxt_drop;
    logic [3:0] nxt_code;

    always_comb begin
        nxt_fatal = fatal_ff | boot_fail;
        nxt_drop = drop_ff;
        nxt_code = code_ff;
        if (rd_error) begin
            nxt_drop = 1'b0;
            nxt_code = SSD_ERR_NONE;
        end
        if (cmd_dropped) begin
            nxt_drop = 1'b1;
        end
        // A new error may only fill an empty field, and a read in the same cycle empties it.
        if (err_event && code_legal(err_code_in) &&
            (code_ff == SSD_ERR_NONE || rd_error)) begin
            nxt_code = err_code_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fatal_ff <= SSD_ERROR_RESET[SSD_ERR_FATAL_BIT];
            drop_ff <= SSD_ERROR_RESET[SSD_ERR_DROP_BIT];
            code_ff <= SSD_ERROR_RESET[SSD_ERR_CODE_LSB +: 4];
        end else begin
            fatal_ff <= nxt_fatal;
            drop_ff <= nxt_drop;
            code_ff <= nxt_code;
        end
    end

    logic [7:0] error_value;

    always_comb begin
        error_value = SSD_READ_ZERO;
        error_value[SSD_ERR_FATAL_BIT] = fatal_ff;
        error_value[SSD_ERR_CODE_LSB +: 4] = code_ff;
        error_value[SSD_ERR_DROP_BIT] = drop_ff;
    end

    // ------------------------------------------------------------
    // Power mode status
    // ------------------------------------------------------------
    ssd_pmu_t pmu_ff;
    ssd_pmu_t nxt_pmu;

    // Modes arrive only when effective; command or event origin is outside this block.
    always_comb begin
        nxt_pmu = pmu_ff;
        if (pm_effective) begin
            if (mode_legal(pm_in.acc, 1'b0)) begin
                nxt_pmu.acc = pm_in.acc;
            end
            if (mode_legal(pm_in.gyr, 1'b1)) begin
                nxt_pmu.gyr = pm_in.gyr;
            end
            if (mode_legal(pm_in.mag, 1'b0)) begin
                nxt_pmu.mag = pm_in.mag;
            end
        end
        nxt_pmu.spare = SSD_PMU_RESET[7:6];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pmu_ff <= SSD_PMU_RESET;
        end else begin
            pmu_ff <= nxt_pmu;
        end
    end

    // ------------------------------------------------------------
    // Data ready flags
    // ------------------------------------------------------------
    ssd_drdy_t drdy_ff;
    ssd_drdy_t nxt_drdy;

    // A new sample in the cycle of the read wins over the clear.
    always_comb begin
        nxt_drdy.mag = (drdy_ff.mag & ~rd_mag) | new_data.mag;
        nxt_drdy.gyr = (drdy_ff.gyr & ~rd_gyr) | new_data.gyr;
        nxt_drdy.acc = (drdy_ff.acc & ~rd_acc) | new_data.acc;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            drdy_ff <= '0;
        end else begin
            drdy_ff <= nxt_drdy;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [7:0] nxt_rdata;
    logic nxt_rvalid;

    // Writes are not decoded at all, so they change no state here.
    always_comb begin
        rd_byte = SSD_READ_ZERO;
        if (host_req.addr == SSD_ADDR_IDENT) begin
            rd_byte = IDENT_VALUE;
        end else if (host_req.addr == SSD_ADDR_ERROR) begin
            rd_byte = error_value;
        end else if (host_req.addr == SSD_ADDR_PMU) begin
            rd_byte = pmu_ff;
        end else if (in_range(host_req.addr, SSD_ADDR_DATA_FIRST, SSD_ADDR_DATA_LAST)) begin
            rd_byte = shadow_vec[data_index * 8 +: 8];
        end
        nxt_rvalid = host_req.rd;
        nxt_rdata = host_req.rd ? rd_byte : rdata_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_ff <= SSD_READ_ZERO;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign rdata = rdata_ff;
    assign rvalid = rvalid_ff;
    assign drdy = drdy_ff;

endmodule // ssd_regs

`default_nettype wire

// *** rtl/ssd_pkg.sv ***
// Package with the register map, field layouts and carrier types of the sensor status block.
package ssd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SSD_ADDR_IDENT = 8'h00;
    localparam logic [7:0] SSD_ADDR_ERROR = 8'h02;
    localparam logic [7:0] SSD_ADDR_PMU = 8'h03;
    localparam logic [7:0] SSD_ADDR_DATA_FIRST = 8'h04;
    localparam logic [7:0] SSD_ADDR_GYR_FIRST = 8'h0C;
    localparam logic [7:0] SSD_ADDR_ACC_FIRST = 8'h12;
    localparam logic [7:0] SSD_ADDR_DATA_LAST = 8'h17;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int SSD_ERR_FATAL_BIT = 0;
    localparam int SSD_ERR_CODE_LSB = 1;
    localparam int SSD_ERR_DROP_BIT = 6;
    localparam logic [7:0] SSD_ERROR_RESET = 8'h00;
    localparam logic [7:0] SSD_PMU_RESET = 8'h00;
    localparam logic [7:0] SSD_READ_ZERO = 8'h00;
    localparam logic [7:0] SSD_IDENT_DEFAULT = 8'h5A;  // Arbitrary neutral value.

    // Error code encodings.
    localparam logic [3:0] SSD_ERR_NONE = 4'h0;
    localparam logic [3:0] SSD_ERR_GENERAL_A = 4'h1;
    localparam logic [3:0] SSD_ERR_GENERAL_B = 4'h2;
    localparam logic [3:0] SSD_ERR_LP_INT_PREFILT = 4'h3;
    localparam logic [3:0] SSD_ERR_ODR_MISMATCH = 4'h6;
    localparam logic [3:0] SSD_ERR_LP_PREFILT = 4'h7;

    // Power mode encodings.
    localparam logic [1:0] SSD_PM_SUSPEND = 2'h0;
    localparam logic [1:0] SSD_PM_NORMAL = 2'h1;
    localparam logic [1:0] SSD_PM_LOW_POWER = 2'h2;
    localparam logic [1:0] SSD_PM_FAST_START = 2'h3;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Host register access from the serial interface, one byte per strobe.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssd_host_req_t;

    // Power modes that have taken effect; layout matches the register.
    typedef struct packed {
        logic [1:0] spare;
        logic [1:0] acc;
        logic [1:0] gyr;
        logic [1:0] mag;
    } ssd_pmu_t;

    // Output data block; mag_x sits in the lowest bits so byte 0 is its low byte.
    typedef struct packed {
        logic [15:0] acc_z;
        logic [15:0] acc_y;
        logic [15:0] acc_x;
        logic [15:0] gyr_z;
        logic [15:0] gyr_y;
        logic [15:0] gyr_x;
        logic [15:0] hall_resistance_word;
        logic [15:0] mag_z;
        logic [15:0] mag_y;
        logic [15:0] mag_x;
    } ssd_data_t;

    // Data ready flags, one per sensor.
    typedef struct packed {
        logic acc;
        logic gyr;
        logic mag;
    } ssd_drdy_t;

endpackage

// *** rtl/ssd_shadow.sv ***
// Shadow copy of the output data block, frozen while a host transaction runs.
`timescale 1ns/1ps
`default_nettype none

module ssd_shadow
    import ssd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hold,
    input wire ssd_data_t live,
    output ssd_data_t shadow
);

    ssd_data_t shadow_ff;
    ssd_data_t nxt_shadow;

    // The copy tracks live data only between transactions, so a burst sees one sample set.
    always_comb begin
        nxt_shadow = shadow_ff;
        if (!hold) begin
            nxt_shadow = live;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shadow_ff <= '0;
        end else begin
            shadow_ff <= nxt_shadow;
        end
    end

    assign shadow = shadow_ff;

endmodule // ssd_shadow

`default_nettype wire

// *** bench/ssd_regs_props.sv ***
// Checker of the sensor status register block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module ssd_regs_props
    import ssd_pkg::*;
#(
    parameter logic [7:0] IDENT_VALUE = SSD_IDENT_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire ssd_host_req_t host_req,
    input wire logic txn_active,
    input wire ssd_data_t live_data,
    input wire ssd_drdy_t new_data,
    input wire logic cmd_dropped,
    input wire logic err_event,
    input wire logic [3:0] err_code_in,
    input wire logic boot_fail,
    input wire logic pm_effective,
    input wire ssd_pmu_t pm_in,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire ssd_drdy_t drdy
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire logic rd = host_req.rd;
wire logic [7:0] adr = host_req.addr;
wire logic rd_err = rd && adr == SSD_ADDR_ERROR;
wire logic rd_pmu = rd && adr == SSD_ADDR_PMU;
wire logic rd_mag = rd && adr >= SSD_ADDR_DATA_FIRST && adr < SSD_ADDR_GYR_FIRST;
wire logic rd_acc = rd && adr >= SSD_ADDR_ACC_FIRST && adr <= SSD_ADDR_DATA_LAST;
AST_IDENT: assert property (rd && adr == SSD_ADDR_IDENT |=> rvalid && rdata == IDENT_VALUE)
    else $error("identification read wrong");
AST_DROP: assert property (cmd_dropped && !rd_err ##1 !rd_err ##1 rd_err |=> rdata[6])
    else $error("dropped command flag missing");
AST_RDCLR: assert property (rd_err && !cmd_dropped ##1 rd_err |=> !rdata[6])
    else $error("error flag survived a read");
AST_FATAL: assert property (boot_fail ##2 rd_err |=> rdata[0])
    else $error("fatal flag missing");
AST_PMU: assert property (rd_pmu |=> rdata[7:6] == 2'h0 && rdata[5:4] != 2'h3
    && rdata[3:2] != 2'h2 && rdata[1:0] != 2'h3) else $error("power mode field illegal");
AST_PM_HOLD: assert property (rd_pmu && !pm_effective ##1 rd_pmu |=> rdata == $past(rdata))
    else $error("power mode changed without effect");
AST_DRDY_SET: assert property (new_data.gyr |=> drdy.gyr)
    else $error("data ready not set");
AST_MAG_CLR: assert property (rd_mag && !new_data.mag |=> !drdy.mag)
    else $error("magnetometer ready not cleared");
AST_ACC_CLR: assert property (rd_acc && !new_data.acc |=> !drdy.acc)
    else $error("accelerometer ready not cleared");
cover property (rd_err ##1 rdata[6]);
cover property (pm_effective ##2 rd_pmu);
cover property (rd_mag && txn_active);
endmodule // ssd_regs_props
bind ssd_regs ssd_regs_props #(.IDENT_VALUE(IDENT_VALUE)) u_props (
    .clk(clk), .reset(reset), .host_req(host_req), .txn_active(txn_active),
    .live_data(live_data), .new_data(new_data), .cmd_dropped(cmd_dropped),
    .err_event(err_event), .err_code_in(err_code_in), .boot_fail(boot_fail),
    .pm_effective(pm_effective), .pm_in(pm_in), .rdata(rdata), .rvalid(rvalid),
    .drdy(drdy));
`default_nettype wire

// *** bench/ssd_host_model.sv ***
// Host model issuing byte reads and writes over the register port.
`timescale 1ns/1ps
`default_nettype none
module ssd_host_model
    import ssd_pkg::*;
(
    input wire logic clk,
    output ssd_host_req_t host_req,
    output logic txn_active,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
logic [7:0] q[$];
initial begin
    host_req = '0;
    txn_active = 1'h0;
end
always @(posedge clk) begin
    #1;
    if (rvalid === 1'h1)
        q.push_back(rdata);
end
// One burst is one transaction; gap idles between bytes for a slow host.
task automatic rd(input logic [7:0] a, input int n, input bit inc, input int gap);
    for (int i = 0; i < n; i++) begin
        @(negedge clk);
        txn_active = 1'h1;
        host_req.rd = 1'h1;
        host_req.addr = inc ? a + 8'(i) : a;
        repeat (gap) begin
            @(negedge clk);
            host_req.rd = 1'h0;
        end
    end
    @(negedge clk);
    host_req.rd = 1'h0;
    txn_active = 1'h0;
    host_req.addr = ~host_req.addr;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req.wr = 1'h1;
    host_req.addr = a;
    host_req.wdata = d;
    @(negedge clk);
    host_req.wr = 1'h0;
endtask
endmodule // ssd_host_model
`default_nettype wire

// *** bench/ssd_regs_tb_top.sv ***
// Self-checking testbench of the sensor status register block.
`timescale 1ns/1ps
`default_nettype none
module ssd_regs_tb_top
    import ssd_pkg::*;
#(
    parameter logic [7:0] ID = 8'h3C  // Arbitrary neutral value.
);
logic clk = 1'h0;
logic reset = 1'h1;
ssd_host_req_t host_req;
logic txn_active, cmd_dropped, err_event, boot_fail, pm_effective, rvalid;
ssd_data_t live_data, old;
ssd_drdy_t new_data, drdy;
logic [3:0] err_code_in;
logic [7:0] rdata;
ssd_pmu_t pm_in, pm_exp;
int fails = 0;
int samples_checked = 0;
int cycles = 0;
integer seed = 32'h78847962;
always #5 clk = ~clk;
ssd_regs #(.IDENT_VALUE(ID)) dut (.clk(clk), .reset(reset), .host_req(host_req),
    .txn_active(txn_active), .live_data(live_data), .new_data(new_data),
    .cmd_dropped(cmd_dropped), .err_event(err_event), .err_code_in(err_code_in),
    .boot_fail(boot_fail), .pm_effective(pm_effective), .pm_in(pm_in),
    .rdata(rdata), .rvalid(rvalid), .drdy(drdy));
ssd_host_model host (.clk(clk), .host_req(host_req), .txn_active(txn_active),
    .rdata(rdata), .rvalid(rvalid));
task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        fails++;
        $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
endtask
task automatic rd1(input logic [7:0] a, input logic [7:0] e);
    host.q.delete();
    host.rd(a, 2, 1'h0, 0);
    // Both bytes are queued before the call returns; wait one more cycle so rvalid is low before the next call.
    @(negedge clk);
    check(host.q[0], e);
endtask
function automatic ssd_pmu_t pm_fn(ssd_pmu_t o, ssd_pmu_t n);
    pm_fn = o;
    if (n.acc != 2'h3) pm_fn.acc = n.acc;
    if (n.gyr != SSD_PM_LOW_POWER) pm_fn.gyr = n.gyr;
    if (n.mag != 2'h3) pm_fn.mag = n.mag;
    pm_fn.spare = 2'h0;
endfunction
function automatic logic [7:0] byte_fn(ssd_data_t d, int k);
    byte_fn = d[8*k +: 8];
endfunction
always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
        fails++;
        summarize();
    end
end
initial begin
    {new_data, cmd_dropped, err_event, boot_fail, pm_effective, err_code_in} = '0;
    pm_in = '0;
    pm_exp = '0;
    live_data = '0;
    repeat (5) @(negedge clk);
    reset = 1'h0;
    rd1(SSD_ADDR_IDENT, ID);
    host.wr(SSD_ADDR_IDENT, ~ID);
    host.wr(SSD_ADDR_ERROR, 8'hFF);
    rd1(SSD_ADDR_IDENT, ID);
    rd1(8'h01, 8'h00);
    rd1(8'h18, 8'h00);
    rd1(SSD_ADDR_ERROR, 8'h00);
    err_code_in = SSD_ERR_ODR_MISMATCH;
    pulse(err_event);
    err_code_in = SSD_ERR_LP_INT_PREFILT;
    pulse(err_event);
    pulse(cmd_dropped);
    rd1(SSD_ADDR_ERROR, 8'h4C);
    rd1(SSD_ADDR_ERROR, 8'h00);
    for (int c = 0; c < 16; c++) begin
        err_code_in = 4'(c);
        pulse(err_event);
        rd1(SSD_ADDR_ERROR, c inside {1, 2, 3, 6, 7} ? {3'h0, 4'(c), 1'h0} : 8'h00);
    end
    pulse(boot_fail);
    rd1(SSD_ADDR_ERROR, 8'h01);
    rd1(SSD_ADDR_ERROR, 8'h01);
    @(negedge clk) reset = 1'h1;
    @(negedge clk) reset = 1'h0;
    rd1(SSD_ADDR_ERROR, 8'h00);
    $display("test error register done");
    for (int i = 0; i < 12; i++) begin
        pm_in = 8'($random(seed));
        rd1(SSD_ADDR_PMU, pm_exp);
        pulse(pm_effective);
        pm_exp = pm_fn(pm_exp, pm_in);
        rd1(SSD_ADDR_PMU, pm_exp);
    end
    $display("test power mode done");
    // The host brings every sensor to normal mode before it reads buffered data.
    pm_in = {2'h0, SSD_PM_NORMAL, SSD_PM_NORMAL, SSD_PM_NORMAL};
    pulse(pm_effective);
    rd1(SSD_ADDR_PMU, pm_in);
    old = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    live_data = old;
    @(negedge clk);
    new_data = '1;
    @(negedge clk);
    new_data = '0;
    check(drdy, 3'h7);
    rd1(SSD_ADDR_GYR_FIRST, byte_fn(old, 8));
    check(drdy, 3'h5);
    rd1(SSD_ADDR_DATA_LAST, byte_fn(old, 19));
    check(drdy, 3'h1);
    host.q.delete();
    fork
        host.rd(SSD_ADDR_DATA_FIRST, 20, 1'h1, 1);
        begin
            repeat (3) @(negedge clk);
            live_data = ~old;
        end
    join
    for (int k = 0; k < 20; k++) check(host.q[k], byte_fn(old, k));
    check(drdy, 3'h0);
    rd1(SSD_ADDR_DATA_FIRST, byte_fn(~old, 0));
    $display("test data block done");
    summarize();
end
endmodule // ssd_regs_tb_top
`default_nettype wire
